// [pkg/sadc_pkg.sv]
// sadc_pkg: constants shared by the serial converter control block
// assumes a single 20 MHz clock mclk; the serial clock is a sampled pin
//
// Overview of operation
// RQ1: serial output changes only on falling edges
// RQ2: data output floats while chip select high
// RQ3: data input sampled on rising edges
// RQ4: input bits ignored unless chip select low
// RQ5: internal mode: strobe low during conversion
// RQ6: external mode: strobe high two periods before msb
// RQ7: strobe floats with chip select high, external only
// RQ8: external mode: serial clock paces conversion steps
// RQ9: power input: low shutdown, float on, high refoff
// RQ10: single-ended: positive channel, negative common return
// RQ11: differential: adjacent pairs only, either polarity
// RQ12: acquisition two cycles, ends after last bit
// RQ13: tracking starts falling edge after sixth bit
// RQ14: hold starts falling edge after eighth bit
// RQ15: hold cap to negative node during conversion
// RQ16: result is eight-bit successive approximation code
// RQ17: control byte starts at first one, msb first
// RQ18: control lsb one selects external clock
// RQ19: control bit two one selects single-ended
// RQ20: result shifted out msb first on falls
package sadc_pkg;
    localparam int unsigned CTRL_W        = 8;
    localparam int unsigned RES_W         = 8;
    localparam int unsigned BIT_CLK_SRC   = 0;
    localparam int unsigned BIT_PWR_MODE  = 1;
    localparam int unsigned BIT_CFG       = 2;
    localparam int unsigned BIT_POL       = 3;
    localparam int unsigned BIT_SEL_LO    = 4;
    localparam int unsigned BIT_SEL_HI    = 6;
    localparam logic [3:0]  TRACK_AT_BIT  = 4'h6;
    localparam logic [3:0]  LAST_BIT      = 4'h8;
    // internal conversion clock: one step every INT_STEP_NS
    localparam int unsigned MCLK_NS       = 50;
    localparam int unsigned INT_STEP_NS   = 1000;
    localparam int unsigned INT_STEP_CYC  = (INT_STEP_NS + MCLK_NS - 1) / MCLK_NS;
    localparam logic [4:0]  INT_STEP_LAST = 5'(INT_STEP_CYC - 1);
    // power state codes on the two-bit power pin reading
    localparam logic [1:0]  PWR_LOW       = 2'h0;
    localparam logic [1:0]  PWR_FLOAT     = 2'h1;
    localparam logic [1:0]  PWR_HIGH      = 2'h2;
    typedef enum logic [4:0] {
        SADC_IDLE  = 5'h01,
        SADC_CTRL  = 5'h02,
        SADC_CONV  = 5'h04,
        SADC_STRB  = 5'h08,
        SADC_SHIFT = 5'h10
    } sadc_state_t;
endpackage : sadc_pkg

// [hdl/sadc_sync.sv]
// sadc_sync: two-flop synchroniser for one pin level
// assumes the pin is asynchronous to mclk
`timescale 1ns/1ps
`default_nettype none
module sadc_sync #(
    parameter logic RST_VAL = 1'b0
) (
    input  wire logic mclk,
    input  wire logic rst_b,
    input  wire logic pin,
    output logic      level
);
    logic meta_q;
    // first flop feeds only the second
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            meta_q <= RST_VAL;
            level  <= RST_VAL;
        end else begin
            meta_q <= pin;
            level  <= meta_q;
        end
    end
endmodule : sadc_sync
`default_nettype wire

// [hdl/sadc_sar.sv]
// sadc_sar: eight-bit successive approximation register
// assumes one step pulse per trial and a comparator answer per step
`timescale 1ns/1ps
`default_nettype none
module sadc_sar (
    input  wire logic                      mclk,
    input  wire logic                      rst_b,
    input  wire logic                      start,
    input  wire logic                      step,
    input  wire logic                      comp_hi,
    output logic [sadc_pkg::RES_W-1:0]     trial,
    output logic [sadc_pkg::RES_W-1:0]     result,
    output logic                           done
);
    logic [sadc_pkg::RES_W-1:0] trial_q, trial_d, mask_q, mask_d, res_q, res_d;
    logic                       done_q, done_d;
    assign trial  = trial_q;
    assign result = res_q;
    assign done   = done_q;
    // one trial bit per step, msb first; keep bit if input above trial
    always_comb begin
        trial_d = trial_q;
        mask_d  = mask_q;
        res_d   = res_q;
        done_d  = 1'b0;
        if (start) begin
            mask_d  = 8'h80;
            trial_d = 8'h80;
        end else if (step && mask_q != 8'h00) begin  // see RQ16
            res_d  = comp_hi ? trial_q : (trial_q & ~mask_q);
            mask_d = mask_q >> 1;
            trial_d = res_d | (mask_q >> 1);
            done_d = (mask_q == 8'h01);
        end
    end
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            trial_q <= 8'h00;
            mask_q  <= 8'h00;
            res_q   <= 8'h00;
            done_q  <= 1'b0;
        end else begin
            trial_q <= trial_d;
            mask_q  <= mask_d;
            res_q   <= res_d;
            done_q  <= done_d;
        end
    end
endmodule : sadc_sar
`default_nettype wire

// [hdl/sadc_ctrl.sv]
// sadc_ctrl: serial port, track/hold sequencing and mux control
// assumes cs_b, sclk, din are pins sampled on mclk; comp_hi from the comparator
`timescale 1ns/1ps
`default_nettype none
module sadc_ctrl (
    input  wire logic       mclk,
    input  wire logic       rst_b,
    input  wire logic       cs_b,
    input  wire logic       sclk,
    input  wire logic       din,
    input  wire logic [1:0] three_level_power_input,
    input  wire logic       comp_hi,
    output logic            dout,
    output logic            dout_oe,
    output logic            conversion_strobe,
    output logic            conversion_strobe_oe,
    output logic [7:0]      pos_node_sel,
    output logic [7:0]      neg_node_sel,
    output logic            neg_is_common,
    output logic            track,
    output logic            hold_cap_to_neg,
    output logic [7:0]      dac_code,
    output logic            polarity_unipolar,
    output logic            device_on,
    output logic            reference_on
);
    logic cs_s, sclk_s, din_s;
    sadc_sync #(.RST_VAL(1'b1)) u_cs   (.mclk(mclk), .rst_b(rst_b), .pin(cs_b), .level(cs_s));
    sadc_sync #(.RST_VAL(1'b0)) u_sclk (.mclk(mclk), .rst_b(rst_b), .pin(sclk), .level(sclk_s));
    sadc_sync #(.RST_VAL(1'b0)) u_din  (.mclk(mclk), .rst_b(rst_b), .pin(din), .level(din_s));
    logic [1:0] pwr_s;
    // power pin is a pin as well; reset values read as floating so outputs do not blink
    sadc_sync #(.RST_VAL(1'b1)) u_pwr0 (.mclk(mclk), .rst_b(rst_b),
        .pin(three_level_power_input[0]), .level(pwr_s[0]));
    sadc_sync #(.RST_VAL(1'b0)) u_pwr1 (.mclk(mclk), .rst_b(rst_b),
        .pin(three_level_power_input[1]), .level(pwr_s[1]));

    logic sclk_prev_q;
    logic rise, fall;
    assign rise = sclk_s & ~sclk_prev_q;
    assign fall = ~sclk_s & sclk_prev_q;
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) sclk_prev_q <= 1'b0;
        else        sclk_prev_q <= sclk_s;
    end

    sadc_pkg::sadc_state_t  st_q, st_d;
    logic [7:0]  ctrl_q, ctrl_d;
    logic [3:0]  cnt_q, cnt_d;       // control bits received
    logic [3:0]  bit_q, bit_d;       // strobe/shift counter
    logic [4:0]  div_q, div_d;
    logic        ext_q, ext_d;
    logic        trk_q, trk_d, hold_q, hold_d, neg_q, neg_d;
    logic        dout_q, dout_d, strb_q, strb_d;
    logic [7:0]  sh_q, sh_d;
    logic        sar_start, sar_step, sar_done;
    logic [7:0]  sar_trial, sar_res;
    logic [7:0]  pos_q, pos_d, negs_q, negs_d;
    logic        negcom_q, negcom_d, uni_q, uni_d;
    logic        on_q, on_d, ref_q, ref_d, oe_q, soe_q;
    logic [7:0]  trial_q;

    sadc_sar u_sar (
        .mclk   (mclk),
        .rst_b  (rst_b),
        .start  (sar_start),
        .step   (sar_step),
        .comp_hi(comp_hi),
        .trial  (sar_trial),
        .result (sar_res),
        .done   (sar_done)
    );

    // control byte capture, acquisition, conversion and result shift
    always_comb begin
        st_d = st_q; ctrl_d = ctrl_q; cnt_d = cnt_q; bit_d = bit_q;
        div_d = div_q; ext_d = ext_q; trk_d = trk_q; hold_d = hold_q;
        neg_d = neg_q; dout_d = dout_q; strb_d = strb_q; sh_d = sh_q;
        sar_start = 1'b0; sar_step = 1'b0;
        case (st_q)
            sadc_pkg::SADC_IDLE: begin
                // leading zeros are ignored until the start bit
                if (!cs_s && rise && din_s) begin          // see RQ3 see RQ4 see RQ17
                    ctrl_d = 8'h01;
                    cnt_d  = 4'h1;
                    st_d   = sadc_pkg::SADC_CTRL;
                end
            end
            sadc_pkg::SADC_CTRL: begin
                if (cs_s) begin                              // see RQ4
                    trk_d = 1'b0;                            // abort must not leave tracking on
                    st_d = sadc_pkg::SADC_IDLE;
                end else if (rise) begin                     // see RQ3
                    ctrl_d = {ctrl_q[6:0], din_s};
                    cnt_d  = cnt_q + 4'h1;
                end else if (fall && cnt_q == sadc_pkg::TRACK_AT_BIT) begin
                    trk_d  = 1'b1;                           // see RQ13 see RQ12
                    hold_d = 1'b0;
                end else if (fall && cnt_q == sadc_pkg::LAST_BIT) begin
                    trk_d  = 1'b0;                           // see RQ14 see RQ12
                    hold_d = 1'b1;
                    neg_d  = 1'b1;                           // see RQ15
                    ext_d  = ctrl_q[sadc_pkg::BIT_CLK_SRC];  // see RQ18
                    sar_start = 1'b1;
                    div_d  = 5'h00;
                    // strobe low in both modes, so the external pulse rises from low
                    strb_d = 1'b0;                           // see RQ5 see RQ6
                    st_d   = sadc_pkg::SADC_CONV;
                end
            end
            sadc_pkg::SADC_CONV: begin
                // external mode steps on serial falls, internal on the divider
                if (ext_q) begin
                    sar_step = fall;                         // see RQ8
                end else begin
                    div_d    = (div_q == sadc_pkg::INT_STEP_LAST) ? 5'h00 : div_q + 5'h01;
                    sar_step = (div_q == sadc_pkg::INT_STEP_LAST);
                end
                if (sar_done) begin
                    neg_d  = 1'b0;                           // see RQ15
                    hold_d = 1'b0;
                    trk_d  = 1'b1;
                    sh_d   = sar_res;
                    bit_d  = 4'h0;
                    if (ext_q) begin
                        strb_d = 1'b1;                       // see RQ6
                        st_d   = sadc_pkg::SADC_STRB;
                    end else begin
                        strb_d = 1'b1;                       // see RQ5
                        st_d   = sadc_pkg::SADC_SHIFT;
                    end
                end
            end
            sadc_pkg::SADC_STRB: begin
                // strobe stands for two serial periods
                if (fall) begin
                    bit_d = bit_q + 4'h1;
                    if (bit_q == 4'h1) begin
                        strb_d = 1'b0;                       // see RQ6
                        dout_d = sh_q[7];                    // see RQ20 see RQ1
                        sh_d   = {sh_q[6:0], 1'b0};
                        bit_d  = 4'h1;
                        st_d   = sadc_pkg::SADC_SHIFT;
                    end
                end
            end
            sadc_pkg::SADC_SHIFT: begin
                if (fall) begin                              // see RQ1 see RQ20
                    dout_d = sh_q[7];
                    sh_d   = {sh_q[6:0], 1'b0};
                    bit_d  = bit_q + 4'h1;
                    if (bit_q == 4'h8) begin
                        dout_d = 1'b0;
                        trk_d  = 1'b0;
                        st_d   = sadc_pkg::SADC_IDLE;
                    end
                end
                if (cs_s) begin
                    trk_d = 1'b0;
                    st_d  = sadc_pkg::SADC_IDLE;
                end
            end
            default: st_d = sadc_pkg::SADC_IDLE;
        endcase
    end

    // multiplexer decode from the captured control byte, power decode from the synchronised power pin
    always_comb begin
        pos_d = 8'h00;
        negs_d = 8'h00;
        uni_d = ctrl_q[sadc_pkg::BIT_POL];
        // channel index is {mid, lo, hi} select bits; hi picks the pair member
        if (ctrl_q[sadc_pkg::BIT_CFG]) begin                 // see RQ19 see RQ10
            pos_d    = 8'h01 << {ctrl_q[5], ctrl_q[4], ctrl_q[6]};
            negcom_d = 1'b1;
        end else begin                                       // see RQ11
            negcom_d = 1'b0;
            pos_d  = 8'h01 << {ctrl_q[5], ctrl_q[4], ctrl_q[6]};
            negs_d = 8'h01 << {ctrl_q[5], ctrl_q[4], ~ctrl_q[6]};
        end
        on_d  = (pwr_s != sadc_pkg::PWR_LOW);                // see RQ9
        ref_d = (pwr_s == sadc_pkg::PWR_FLOAT);              // see RQ9
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            st_q <= sadc_pkg::SADC_IDLE;
            ctrl_q <= 8'h00; cnt_q <= 4'h0; bit_q <= 4'h0; div_q <= 5'h00;
            ext_q <= 1'b0; trk_q <= 1'b0; hold_q <= 1'b0; neg_q <= 1'b0;
            dout_q <= 1'b0; strb_q <= 1'b1; sh_q <= 8'h00;
            pos_q <= 8'h00; negs_q <= 8'h00; negcom_q <= 1'b1; uni_q <= 1'b1;
            on_q <= 1'b1; ref_q <= 1'b1; oe_q <= 1'b0; soe_q <= 1'b1;
            trial_q <= 8'h00;
        end else begin
            st_q <= st_d;
            ctrl_q <= ctrl_d; cnt_q <= cnt_d; bit_q <= bit_d; div_q <= div_d;
            ext_q <= ext_d; trk_q <= trk_d; hold_q <= hold_d; neg_q <= neg_d;
            dout_q <= dout_d; strb_q <= strb_d; sh_q <= sh_d;
            pos_q <= pos_d; negs_q <= negs_d; negcom_q <= negcom_d; uni_q <= uni_d;
            on_q <= on_d; ref_q <= ref_d;
            oe_q  <= ~cs_s;                                  // see RQ2
            soe_q <= ~(cs_s & ext_d);                        // see RQ7
            trial_q <= sar_trial;
        end
    end

    assign dout                 = dout_q;
    assign dout_oe              = oe_q;
    assign conversion_strobe    = strb_q;
    assign conversion_strobe_oe = soe_q;
    assign pos_node_sel         = pos_q;
    assign neg_node_sel         = negs_q;
    assign neg_is_common        = negcom_q;
    assign track                = trk_q;
    assign hold_cap_to_neg      = neg_q;
    assign dac_code             = trial_q;
    assign polarity_unipolar    = uni_q;
    assign device_on            = on_q;
    assign reference_on         = ref_q;
endmodule : sadc_ctrl
`default_nettype wire

// [sim/sadc_ctrl_assertions.sv]
// sadc_chk: port-level checks on the serial converter control block
// assumes it is bound onto sadc_ctrl; pins reach the block through a 2-flop sync
`timescale 1ns/1ps
`default_nettype none
module sadc_chk (
    input  wire logic       mclk,
    input  wire logic       rst_b,
    input  wire logic       cs_b,
    input  wire logic       sclk,
    input  wire logic [1:0] three_level_power_input,
    input  wire logic       dout,
    input  wire logic       dout_oe,
    input  wire logic       conversion_strobe_oe,
    input  wire logic [7:0] pos_node_sel,
    input  wire logic [7:0] neg_node_sel,
    input  wire logic       neg_is_common,
    input  wire logic       track,
    input  wire logic       hold_cap_to_neg,
    input  wire logic       device_on,
    input  wire logic       reference_on
);
    logic       sclk_q;
    logic [3:0] age_q;
    logic [3:0] age_d;
    // cycles since the raw serial clock last fell, saturating so it never wraps
    always_comb begin
        age_d = (age_q == 4'hF) ? age_q : age_q + 4'h1;
        if (sclk_q && !sclk) age_d = 4'h0;
    end
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            sclk_q <= 1'b0;
            age_q  <= 4'hF;
        end else begin
            sclk_q <= sclk;
            age_q  <= age_d;
        end
    end
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_b);
    // five cycles covers the sync flops plus the output register
    sequence s_cs_high; cs_b [*5]; endsequence
    sequence s_cs_low; !cs_b [*5]; endsequence
    sequence s_hold; $fell(track) && (age_q <= 4'h7); endsequence
    chk_dout_float: assert property (s_cs_high |-> !dout_oe)
        else $error("data output driven while deselected");
    chk_strb_driven: assert property (s_cs_low |-> conversion_strobe_oe)
        else $error("strobe floating while selected");
    chk_dout_on_fall: assert property (
        dout_oe && $past(dout_oe) && $changed(dout) |-> age_q <= 4'h7)
        else $error("data output moved away from a clock fall");
    // cap moves to the negative node in the very cycle tracking stops, near a fall
    chk_hold_at_fall: assert property ($rose(hold_cap_to_neg) |-> s_hold)
        else $error("hold not entered at a clock fall with cap to negative");
    chk_pwr_low: assert property (
        (three_level_power_input == sadc_pkg::PWR_LOW) [*4] |-> !device_on)
        else $error("device on with power input low");
    chk_pwr_float: assert property (
        (three_level_power_input == sadc_pkg::PWR_FLOAT) [*4] |-> device_on && reference_on)
        else $error("device not fully on with power input floating");
    chk_pwr_high: assert property (
        (three_level_power_input == sadc_pkg::PWR_HIGH) [*4] |-> device_on && !reference_on)
        else $error("reference not off with power input high");
    chk_diff_pair: assert property (
        !neg_is_common && pos_node_sel != 8'h00
        |-> neg_node_sel == (((pos_node_sel & 8'h55) << 1) | ((pos_node_sel & 8'hAA) >> 1)))
        else $error("differential nodes not an adjacent pair");
endmodule : sadc_chk
bind sadc_ctrl sadc_chk u_chk (.mclk, .rst_b, .cs_b, .sclk, .three_level_power_input,
    .dout, .dout_oe, .conversion_strobe_oe, .pos_node_sel, .neg_node_sel,
    .neg_is_common, .track, .hold_cap_to_neg, .device_on, .reference_on);
`default_nettype wire

// [sim/sadc_host.sv]
// sadc_host: behavioural serial host that writes a control byte and reads the result
// assumes a 400 ns serial clock, idle between frames, data sampled late in the high phase
`timescale 1ns/1ps
`default_nettype none
module sadc_host (
    output logic      cs_b,
    output logic      sclk,
    output logic      din,
    input  wire logic dout,
    input  wire logic conversion_strobe,
    input  wire logic track
);
    initial begin
        cs_b = 1'b1;
        sclk = 1'b0;
        din  = 1'b0;
    end
    // one period, fall then rise at 50% duty; data read just before the next fall
    task automatic per(input logic d, output logic s);
        sclk = 1'b0;
        din  = d;
        #200 sclk = 1'b1;
        #190 s = dout;
        #10;
    endtask : per
    // start bit leads, msb first; strobe seen high then two falls bring the msb in external mode, one fall in internal mode
    task automatic frame(input logic [7:0] cb, input int lz, output logic [7:0] res,
                         output logic th, output logic t7, output int hc);
        logic s;
        int   ph;
        int   n;
        int   fb;
        ph = 0;
        n = 0;
        // external mode spends one fall inside the strobe; internal shows the msb at once
        fb = cb[0] ? 2 : 1;
        hc = 0;
        res = 8'h00;
        cs_b = 1'b0;
        #100;
        repeat (lz) per(1'b0, s);
        for (int i = 7; i >= 0; i--) begin
            per(cb[i], s);
            if (i == 1) t7 = track;
        end
        per(1'b0, s);
        th = track;
        // internal mode keeps the clock still until the strobe reports done
        for (int k = 0; k < 2000 && n < fb + 7; k++) begin
            if (cb[0] || ph == 2) begin
                per(1'b0, s);
                if (ph == 2) n++;
                if (n >= fb) res = {res[6:0], s};
            end else #50;
            if (ph == 0 && conversion_strobe === 1'b0) ph = 1;
            else if (ph == 1 && conversion_strobe === 1'b1) ph = 2;
            if (ph == 2 && conversion_strobe === 1'b1) hc++;
        end
    endtask : frame
    task automatic rel();
        cs_b = 1'b1;
        din  = ~din;
    endtask : rel
endmodule : sadc_host
`default_nettype wire

// [sim/serial_adc_sample_control_tb.sv]
// serial_adc_sample_control_tb: random control bytes and levels through a host model
// assumes a comparator model here; the host model drives the serial pins
`timescale 1ns/1ps
`default_nettype none
module serial_adc_sample_control_tb;
    logic        mclk = 1'b0;
    logic        rst_b = 1'b0;
    logic [1:0]  pwr = sadc_pkg::PWR_FLOAT;
    logic [7:0]  vin = 8'h00;
    logic [31:0] lfsr = 32'h5442;
    logic        cs_b, sclk, din, comp_hi, dout, dout_oe, strb, strb_oe;
    logic        neg_com, track, hcn, unip, dev_on, ref_on;
    logic [7:0]  pos, neg, dac;
    int          err_total = 0;
    int          checked = 0;
    always #25 mclk = ~mclk;
    // input sits half a code above vin, so a full search lands exactly on vin
    assign comp_hi = (vin >= dac);
    sadc_host h (.cs_b, .sclk, .din, .dout, .conversion_strobe(strb), .track);
    sadc_ctrl DUT (.mclk, .rst_b, .cs_b, .sclk, .din, .three_level_power_input(pwr),
        .comp_hi, .dout, .dout_oe, .conversion_strobe(strb), .conversion_strobe_oe(strb_oe),
        .pos_node_sel(pos), .neg_node_sel(neg), .neg_is_common(neg_com), .track,
        .hold_cap_to_neg(hcn), .dac_code(dac), .polarity_unipolar(unip),
        .device_on(dev_on), .reference_on(ref_on));
    function automatic logic [31:0] nxt(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction : nxt
    task automatic chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : print_verdict
    // about 14 frames of at most 20 us each; the limit leaves ample margin
    initial begin
        #2000000;
        err_total++;
        print_verdict();
    end
    initial begin
        logic [7:0] cb;
        logic [7:0] res;
        logic       th;
        logic       t7;
        logic       s;
        int         hc;
        repeat (4) @(negedge mclk);
        rst_b <= 1'b1;
        repeat (3) @(negedge mclk);
        chk("reset", {dout_oe, strb, strb_oe, track, dev_on, ref_on}, 8'h1B);
        $display("test reset done");
        // clock a start bit pattern with the chip deselected
        repeat (8) h.per(1'b1, s);
        #400 chk("ignored", {track, dout_oe}, 8'h00);
        $display("test deselected done");
        for (int p = 0; p < 3; p++) begin
            @(negedge mclk) pwr <= 2'(p);
            repeat (6) @(negedge mclk);
            chk("device_on", dev_on, 8'(p != 0));
            if (p != 0) chk("ref_on", ref_on, 8'(p == 1));
        end
        @(negedge mclk) pwr <= sadc_pkg::PWR_FLOAT;
        repeat (6) @(negedge mclk);
        $display("test power done");
        for (int f = 0; f < 14; f++) begin
            lfsr = nxt(lfsr);
            cb = {1'b1, lfsr[6:2], 1'b1, f[0]};
            @(negedge mclk) vin <= (f == 0) ? 8'h00 : (f == 1) ? 8'hFF : lfsr[15:8];
            h.frame(cb, int'(lfsr[17:16]), res, th, t7, hc);
            chk("result", res, vin);
            chk("track", {t7, th}, 8'h02);
            if (cb[0]) chk("strobe_len", 8'(hc), 8'h02);
            chk("pos", pos, 8'h01 << {cb[5], cb[4], cb[6]});
            if (cb[2]) chk("neg_common", neg_com, 8'h01);
            else chk("neg", neg, 8'h01 << {cb[5], cb[4], ~cb[6]});
            chk("unipolar", unip, cb[3]);
            chk("retrack", {hcn, track}, 8'h01);
            h.rel();
            #600 chk("float", {dout_oe, strb_oe}, {6'h00, 1'b0, ~cb[0]});
            $display("test frame %0d done", f);
        end
        print_verdict();
    end
endmodule : serial_adc_sample_control_tb
`default_nettype wire
